// >>> design/spims_port.sv
// Serial port, master or slave, with its AXI4-Lite register file
// Behaviour
// - control bit picks slave (0) or master (1); master makes clock and select
// - width code 00..11 gives 8, 9, 16 or 17 bit frames
// - bit order 0 sends LSB first, 1 sends MSB first
// - equal polarity and phase sample rising edge; mixed ones sample falling
// - phase 0 samples odd clock edges, phase 1 even edges
// - clock polarity bit inverts serial clock waveform only
// - select polarity 0 means active low, 1 active high, both directions
// - select pin driven only when select output enable is set
// - master manual mode puts manual level on select, else automatic select
// - slave takes data only while selected unless select is ignored
// - master loopback feeds transmit bit back into receive path
// - writing 1 to a flush bit empties that buffer; bits are write-only
// - select edge interrupt enable raises interrupt on both select edges
// - transmit and receive interrupt enables gate their requests
// - DMA done interrupt enables gate the DMA done interrupts
// - status flags mark DMA transmit and receive completion
// - one offset: write loads transmit buffer, read returns received data
// - pin directions follow master or slave mode
// - transmit ready clears on data write; receive ready clears on read
// - overrun sets on arrival into full buffer; clears on data access
// - serial clock is clock divided by divider plus one, divider one up
`timescale 1ns/10ps
module spims_port
  import spims_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire spims_pins_t pin_in,
  output      spims_pins_t pin_out,
  output      spims_pins_t pin_oe,
  input  wire logic        dma_tx_done,
  input  wire logic        dma_rx_done,
  output      logic        dma_tx_req,
  output      logic        dma_rx_req,
  output      logic        irq
);
  // ********************************************************************
  // State
  // ********************************************************************
  logic [18:0]  ctrl;
  logic [15:0]  div;
  logic         en;
  logic [23:0]  len;
  logic         aw_got, w_got;
  logic [7:0]   aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic [16:0]  tx_buf, rx_buf, cur, rx_word, next_rx_word;
  logic         tx_full, rx_full, ovr, udr, ssdet, tx_dma_complete, rx_dma_complete;
  spims_pins_t  pin_s1, pin_s2, pin_s3;
  spims_state_t st;
  logic [15:0]  cnt;
  logic [7:0]   dcnt;
  logic [5:0]   e;
  logic         en_d, sel_d;

  // ********************************************************************
  // Bus decode
  // ********************************************************************
  wire        aw_hs       = s_axi_awvalid & s_axi_awready;
  wire        w_hs        = s_axi_wvalid & s_axi_wready;
  wire        ar_hs       = s_axi_arvalid & s_axi_arready;
  wire        do_wr       = aw_got & w_got;
  wire        next_aw_got = (aw_got | aw_hs) & ~do_wr;
  wire        next_w_got  = (w_got | w_hs) & ~do_wr;
  wire        next_bvalid = do_wr | (s_axi_bvalid & ~s_axi_bready);
  wire        next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  wire [31:0] wm          = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wd          = w_data & wm;
  wire        wr_data     = do_wr & (aw_addr == OFS_DATA);
  wire        wr_ctrl     = do_wr & (aw_addr == OFS_CTRL);
  wire        wr_stat     = do_wr & (aw_addr == OFS_STAT);
  wire        wr_div      = do_wr & (aw_addr == OFS_DIV);
  wire        wr_en       = do_wr & (aw_addr == OFS_EN);
  wire        wr_len      = do_wr & (aw_addr == OFS_LEN);
  wire        wr_ok       = wr_data | wr_ctrl | wr_stat | wr_div | wr_en | wr_len;
  wire        rd_data     = ar_hs & (s_axi_araddr == OFS_DATA);
  wire        tx_flush    = wr_ctrl & wd[CB_TXFL];
  wire        rx_flush    = wr_ctrl & wd[CB_RXFL];
  wire        en_off      = wr_en & wm[0] & ~w_data[0];

  // ********************************************************************
  // Mode and frame geometry
  // ********************************************************************
  wire       master = ctrl[CB_MS];
  wire       clock_idle_polarity   = ctrl[CB_CLOCK_IDLE_POLARITY];
  wire       clock_phase   = ctrl[CB_CLOCK_PHASE];
  wire       first_bit_order   = ctrl[CB_FIRST_BIT_ORDER];
  logic [5:0] nbits;
  always_comb
  begin
    unique case (ctrl[CB_WID +: 2])
      2'h0: nbits = 6'd8;
      2'h1: nbits = 6'd9;
      2'h2: nbits = 6'd16;
      2'h3: nbits = 6'd17;
    endcase
  end
  wire [5:0] last_e = (nbits << 1) - 6'd1;

  // Bit position of the outgoing and incoming bit for the current edge count
  wire [5:0] k_out  = (clock_phase & (e != 6'd0)) ? ((e - 6'd1) >> 1) : (e >> 1);
  wire [5:0] k_in   = e >> 1;
  wire [5:0] p_out  = first_bit_order ? (nbits - 6'd1 - k_out) : k_out;
  wire [5:0] p_in   = first_bit_order ? (nbits - 6'd1 - k_in) : k_in;
  wire       tx_bit = cur[p_out[4:0]];

  // ********************************************************************
  // Edge sources: divider in master, synchronised pins in slave
  // ********************************************************************
  wire [15:0] half    = div >> 1;
  wire        p_tick  = (cnt == div);
  wire        m_edge  = (st == ST_XFER) & ((cnt == half) | p_tick);
  wire        sel_act = pin_s2.sel ^ ~ctrl[CB_SELECT_POLARITY];
  wire        sel_pre = pin_s3.sel ^ ~ctrl[CB_SELECT_POLARITY];
  wire        s_sel   = ctrl[CB_IGN] | sel_act;
  wire        s_edge  = ~master & en & s_sel & (pin_s2.sclk ^ pin_s3.sclk);
  wire        edge_ev = master ? m_edge : s_edge;
  wire        smp     = edge_ev & (e[0] == clock_phase);
  wire        in_bit  = master ? (ctrl[CB_LBE] ? tx_bit : pin_s2.miso) : pin_s2.mosi;
  wire        f_end   = edge_ev & (e == last_e);
  wire        go      = en & (tx_full | (en & ~en_d));
  wire        m_load  = ((st == ST_IDLE) & go) | ((st == ST_GAP) & p_tick & (dcnt == 8'd1));
  wire        s_load  = ~master & en & ((s_sel & ~sel_d) | f_end);
  wire        load    = master ? m_load : s_load;
  wire        idle    = (st == ST_IDLE) & (master | (e == 6'd0));

  // Receive word including the bit taken at this edge
  always_comb
  begin
    next_rx_word = rx_word;
    if (smp)
      next_rx_word[p_in[4:0]] = in_bit;
  end

  // ********************************************************************
  // Pin synchroniser
  // ********************************************************************
  always_ff @(posedge aclk)
  begin
    pin_s1 <= pin_in;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  // ********************************************************************
  // Bus slave handshake
  // ********************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      s_axi_awready <= ~next_aw_got & ~next_bvalid;
      s_axi_wready  <= ~next_w_got & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (aw_hs)
        aw_addr <= s_axi_awaddr;
      if (w_hs)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr)
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLV;
      if (ar_hs)
      begin
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          OFS_DATA: s_axi_rdata <= {15'h0000, rx_buf};
          OFS_CTRL: s_axi_rdata <= {13'h0000, ctrl};
          OFS_STAT: s_axi_rdata <= {22'h000000, tx_dma_complete, rx_dma_complete, 1'b0, ssdet, sel_act,
                                    ovr, udr, idle, ~tx_full, rx_full};
          OFS_DIV:  s_axi_rdata <= {16'h0000, div};
          OFS_EN:   s_axi_rdata <= {31'h00000000, en};
          OFS_LEN:  s_axi_rdata <= {8'h00, len};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLV;
          end
        endcase
      end
    end
  end

  // ********************************************************************
  // Configuration registers
  // ********************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= CTRL_RST;
      div  <= DIV_RST;
      en   <= 1'b0;
      len  <= LEN_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= ((ctrl & ~wm[18:0]) | wd[18:0]) & CTRL_MASK;
      if (wr_div)
        div <= (div & ~wm[15:0]) | wd[15:0];
      if (wr_en & wm[0])
        en <= w_data[0];
      if (wr_len)
        len <= (len & ~wm[23:0]) | wd[23:0];
    end
  end

  // ********************************************************************
  // Buffers and status flags; a hardware set wins over a clear, except overrun, which a same-cycle data read suppresses
  // ********************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_buf  <= 17'h00000;
      rx_buf  <= 17'h00000;
      tx_full <= 1'b0;
      rx_full <= 1'b0;
      ovr     <= 1'b0;
      udr     <= 1'b0;
      ssdet   <= 1'b0;
      tx_dma_complete  <= 1'b0;
      rx_dma_complete  <= 1'b0;
      cur     <= 17'h00000;
    end
    else
    begin
      if (wr_data)
        tx_buf <= w_data[16:0];
      tx_full <= (wr_data | (tx_full & ~load)) & ~tx_flush;
      rx_full <= (f_end | (rx_full & ~rd_data & ~en_off)) & ~(rx_flush & ~f_end);
      ovr     <= (f_end & rx_full & ~rd_data) | (ovr & ~rd_data & ~wr_data & ~en_off);
      udr     <= (load & ~tx_full) | (udr & ~wr_data & ~rd_data & ~en_off);
      ssdet   <= (sel_act ^ sel_pre) | (ssdet & ~(wr_stat & wm[SB_SSDET] & ~w_data[SB_SSDET])
                 & ~en_off);
      tx_dma_complete  <= dma_tx_done | (tx_dma_complete & ~(wr_stat & wm[SB_TXDMA] & ~w_data[SB_TXDMA])
                 & ~en_off);
      rx_dma_complete  <= dma_rx_done | (rx_dma_complete & ~(wr_stat & wm[SB_RXDMA] & ~w_data[SB_RXDMA])
                 & ~en_off);
      if (f_end)
        rx_buf <= next_rx_word;
      if (load & tx_full)
        cur <= tx_buf;
    end
  end

  // ********************************************************************
  // Transfer sequencer: start delay, frame, burst gap, stop delay
  // ********************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st      <= ST_IDLE;
      cnt     <= 16'h0000;
      dcnt    <= 8'h00;
      e       <= 6'd0;
      rx_word <= 17'h00000;
      en_d    <= 1'b0;
      sel_d   <= 1'b0;
    end
    else
    begin
      en_d    <= en;
      sel_d   <= s_sel;
      cnt     <= (p_tick | (st == ST_IDLE)) ? 16'h0000 : cnt + 16'h0001;
      rx_word <= load ? 17'h00000 : next_rx_word;
      if (load | f_end | (~master & ~s_sel) | ~en)
        e <= 6'd0;
      else if (edge_ev)
        e <= e + 6'd1;
      if (~master | ~en)
        st <= ST_IDLE;
      else
      begin
        unique case (st)
          ST_IDLE:
            if (go)
            begin
              st   <= ST_START;
              dcnt <= len[7:0];
            end
          ST_START, ST_GAP, ST_STOP:
            if (p_tick)
            begin
              dcnt <= dcnt - 8'd1;
              if (dcnt <= 8'd1)
                st <= (st == ST_STOP) ? ST_IDLE : ST_XFER;
            end
          ST_XFER:
            if (f_end)
            begin
              st   <= tx_full ? ST_GAP : ST_STOP;
              dcnt <= tx_full ? len[15:8] : len[23:16];
            end
        endcase
      end
    end
  end

  // ********************************************************************
  // Pin drivers, DMA requests and interrupt
  // ********************************************************************
  wire sel_auto = (st != ST_IDLE) ^ ~ctrl[CB_SELECT_POLARITY];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out    <= '0;
      pin_oe     <= '0;
      dma_tx_req <= 1'b0;
      dma_rx_req <= 1'b0;
      irq        <= 1'b0;
    end
    else
    begin
      pin_out.sel  <= ctrl[CB_SSMAN] ? ctrl[CB_SSLVL] : sel_auto;
      pin_out.sclk <= clock_idle_polarity ^ ((st == ST_XFER) & e[0]);
      pin_out.mosi <= tx_bit;
      pin_out.miso <= tx_bit;
      pin_oe.sel   <= master & ctrl[CB_SSOE];
      pin_oe.sclk  <= master;
      pin_oe.mosi  <= master;
      pin_oe.miso  <= ~master & en & s_sel;
      dma_tx_req   <= en & ~tx_full;
      dma_rx_req   <= rx_full;
      irq <= (ctrl[CB_TX_IRQ_EN] & ~tx_full) | (ctrl[CB_RX_IRQ_EN] & rx_full)
           | (ctrl[CB_SELECT_EDGE_IRQ_EN] & ssdet)
           | (ctrl[CB_TX_DMA_DONE_IRQ_EN] & tx_dma_complete) | (ctrl[CB_RX_DMA_DONE_IRQ_EN] & rx_dma_complete);
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  frame_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    f_end |-> (e == ((ctrl[CB_WID+1] ? 6'd31 : 6'd15) + (ctrl[CB_WID] ? 6'd2 : 6'd0))))
    else $error("frame ended at wrong edge count");
  idle_clock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (master && st == ST_IDLE) |=> pin_out.sclk == $past(clock_idle_polarity))
    else $error("idle serial clock level wrong");
  sel_manual_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl[CB_SSMAN] |=> pin_out.sel == $past(ctrl[CB_SSLVL]))
    else $error("manual select level not driven");
  sel_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl[CB_SSOE] |=> !pin_oe.sel)
    else $error("select driven while disabled");
  tx_flush_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_flush |=> !tx_full)
    else $error("transmit flush left data");
  tx_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_data && !tx_flush) |=> tx_full && tx_buf == $past(w_data[16:0]))
    else $error("transmit write not taken");
  rx_overrun_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (f_end && rx_full && !rd_data) |=> ovr)
    else $error("overrun not flagged");
  dma_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dma_tx_done |=> tx_dma_complete ##0 (tx_dma_complete || !$past(dma_tx_done, 2)))
    else $error("transmit dma flag not set");
  slave_pins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !master [*2] |-> !pin_oe.sclk && !pin_oe.mosi && !pin_oe.sel)
    else $error("slave drives master pins");
endmodule

// >>> include/spims_pkg.sv
// Package with register map, field positions, reset values and shared types of the serial port
package spims_pkg;
  // ********************************************************************
  // Register offsets
  // ********************************************************************
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DIV  = 8'h0C;
  localparam logic [7:0] OFS_EN   = 8'h10;
  localparam logic [7:0] OFS_LEN  = 8'h14;
  // ********************************************************************
  // Reset values and masks
  // ********************************************************************
  localparam logic [18:0] CTRL_RST  = 19'h01020;
  localparam logic [18:0] CTRL_MASK = 19'h7FF3F;
  localparam logic [9:0]  STAT_RST  = 10'h006;
  localparam logic [15:0] DIV_RST   = 16'h00FF;
  localparam logic [23:0] LEN_RST   = 24'h010101;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;
  // ********************************************************************
  // Control field positions
  // ********************************************************************
  localparam int CB_WID   = 0;
  localparam int CB_CLOCK_IDLE_POLARITY  = 2;
  localparam int CB_CLOCK_PHASE  = 3;
  localparam int CB_FIRST_BIT_ORDER  = 4;
  localparam int CB_MS    = 5;
  localparam int CB_SELECT_POLARITY = 8;
  localparam int CB_SSOE  = 9;
  localparam int CB_IGN   = 10;
  localparam int CB_LBE   = 11;
  localparam int CB_SSLVL = 12;
  localparam int CB_SSMAN = 13;
  localparam int CB_RX_IRQ_EN  = 14;
  localparam int CB_TX_IRQ_EN  = 15;
  localparam int CB_SELECT_EDGE_IRQ_EN = 16;
  localparam int CB_RX_DMA_DONE_IRQ_EN = 17;
  localparam int CB_TX_DMA_DONE_IRQ_EN = 18;
  localparam int CB_RXFL  = 19;
  localparam int CB_TXFL  = 20;
  // ********************************************************************
  // Status field positions
  // ********************************************************************
  localparam int SB_RXF   = 0;
  localparam int SB_TXE   = 1;
  localparam int SB_IDLE  = 2;
  localparam int SB_UDR   = 3;
  localparam int SB_OVR   = 4;
  localparam int SB_SSON  = 5;
  localparam int SB_SSDET = 6;
  localparam int SB_RXDMA = 8;
  localparam int SB_TXDMA = 9;
  // ********************************************************************
  // Types
  // ********************************************************************
  typedef struct packed {
    logic sel;
    logic sclk;
    logic mosi;
    logic miso;
  } spims_pins_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_START = 5'b00010,
    ST_XFER  = 5'b00100,
    ST_GAP   = 5'b01000,
    ST_STOP  = 5'b10000
  } spims_state_t;
endpackage

// >>> tb/spims_peer.sv
// Peer model of an external serial slave on the port pins
`timescale 1ns/10ps
module spims_peer
(
  input  wire logic        aclk,
  input  wire logic        sel_n,
  input  wire logic        sclk,
  input  wire logic        mosi,
  output      logic        miso,
  input  wire logic [4:0]  nbits,
  input  wire logic        first_bit_order,
  input  wire logic        clock_idle_polarity,
  input  wire logic        clock_phase,
  input  wire logic [16:0] tx_word,
  output      logic [16:0] rx_word
);
  int   oi;
  int   ri;
  logic drv = 1'b0;
  // Word bit sent at a given frame position
  function automatic logic pick(int i);
    int j;
    j = first_bit_order ? nbits - 1 - i : i;
    return (j >= 0 && j < 17) ? tx_word[j] : 1'b0;
  endfunction
  // Active-low select opens a frame; phase 0 presents the first bit at once
  always @(negedge sel_n)
  begin
    ri = 0;
    oi = 0;
    rx_word = '0;
    if (!clock_phase)
    begin
      drv = pick(0);
      oi = 1;
    end
  end
  // Sample on one clock edge, shift on the other
  always @(sclk)
  begin
    if (!sel_n)
    begin
      if ((sclk != clock_idle_polarity) == !clock_phase)
      begin
        if (ri < nbits)
          rx_word[first_bit_order ? nbits - 1 - ri : ri] = mosi;
        ri++;
      end
      else
      begin
        drv = pick(oi);
        oi++;
      end
    end
  end
  // Released data line never holds its last value
  always @(posedge aclk)
    if (sel_n)
      drv <= ~drv;
  assign miso = drv;
endmodule

// >>> tb/spims_port_test.sv
// Self-checking bench for the serial port with a peer model on the pins
`timescale 1ns/10ps
module spims_port_test import spims_pkg::*;;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd_data;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq, txreq, rxreq;
  logic        dtx = 0, drx = 0, first_bit_order = 0, clock_idle_polarity = 0, clock_phase = 0, pmiso, sclk_q = 0;
  logic [1:0]  bresp, rresp, rd_resp;
  logic [4:0]  nbits = 5'h08;
  logic [16:0] prx;
  spims_pins_t pin_in, pin_out, pin_oe;
  int          mismatches = 0, checks = 0, cyc = 0, per = 0;
  spims_port DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .dma_tx_done(dtx), .dma_rx_done(drx), .dma_tx_req(txreq), .dma_rx_req(rxreq), .irq(irq));
  spims_peer peer (.aclk(aclk), .sel_n(pin_in.sel), .sclk(pin_in.sclk), .mosi(pin_in.mosi),
    .miso(pmiso), .nbits(nbits), .first_bit_order(first_bit_order), .clock_idle_polarity(clock_idle_polarity), .clock_phase(clock_phase),
    .tx_word(17'h0B4E9), .rx_word(prx));
  // Wire levels; select is pulled up and clock pulled down on the board
  assign pin_in = {pin_oe.sel ? pin_out.sel : 1'b1, pin_oe.sclk ? pin_out.sclk : 1'b0,
                   pin_oe.mosi ? pin_out.mosi : ~pmiso, pin_oe.miso ? pin_out.miso : pmiso};
  initial
    forever #2 aclk = ~aclk;
  // Cycles between serial clock rises
  always @(posedge aclk)
  begin
    sclk_q <= pin_out.sclk;
    cyc <= (pin_out.sclk && !sclk_q) ? 1 : cyc + 1;
    if (pin_out.sclk && !sclk_q)
      per <= cyc;
  end
  // ********
  // Bus tasks and comparisons
  // ********
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic give_up();
    mismatches++;
    $display("mismatch at %0t: wait ran out", $time);
    close_out();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100 && !(bready && bvalid); n++)
    begin
      @(posedge aclk);
      if (awready && awvalid)
        awvalid <= 1'b0;
      if (wready && wvalid)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (n == 100)
      give_up();
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100 && !(rready && rvalid); n++)
    begin
      @(posedge aclk);
      if (arready && arvalid)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    rd_data = rdata;
    rd_resp = rresp;
    if (n == 100)
      give_up();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk_word(rd_data, exp);
  endtask
  task automatic poll(input int b);
    int n;
    rd(OFS_STAT);
    for (n = 0; n < 400 && rd_data[b] !== 1'b1; n++)
      rd(OFS_STAT);
    if (n == 400)
      give_up();
  endtask
  // Main sequence
  initial
  begin
    int i;
    logic [16:0] mask;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(OFS_CTRL, 32'h00001020);
    rdc(OFS_STAT, 32'h00000006);
    rdc(OFS_DIV, 32'h000000FF);
    rdc(OFS_EN, 32'h00000000);
    rdc(OFS_LEN, 32'h00010101);
    rdc(8'h18, 32'h00000000);
    chk_word(rd_resp, RESP_SLV);
    wr(OFS_CTRL, 32'hFFFFFFFF);
    rdc(OFS_CTRL, 32'h0007FF3F);
    chk_bit(pin_oe.sel, 1'b1);
    chk_bit(pin_out.sel, 1'b1);
    chk_bit(pin_oe.miso, 1'b0);
    wr(OFS_CTRL, 32'h00002220);
    rd(OFS_STAT);
    chk_bit(pin_out.sel, 1'b0);
    wr(OFS_CTRL, 32'h00002020);
    rd(OFS_STAT);
    chk_bit(pin_oe.sel, 1'b0);
    chk_bit(pin_oe.sclk, 1'b1);
    wr(OFS_CTRL, 32'h00000320);
    rd(OFS_STAT);
    chk_bit(pin_out.sel, 1'b0);
    wr(OFS_CTRL, 32'h00000224);
    rd(OFS_STAT);
    chk_bit(pin_out.sel, 1'b1);
    chk_bit(pin_out.sclk, 1'b1);
    wr(OFS_CTRL, 32'h00000000);
    rd(OFS_STAT);
    chk_bit(pin_oe.sclk, 1'b0);
    wr(OFS_DATA, 32'h00000055);
    rd(OFS_STAT);
    chk_bit(rd_data[SB_TXE], 1'b0);
    wr(OFS_CTRL, 32'h00108000);
    rd(OFS_STAT);
    chk_bit(rd_data[SB_TXE], 1'b1);
    chk_bit(irq, 1'b1);
    wr(OFS_CTRL, 32'h00000000);
    rd(OFS_STAT);
    chk_bit(irq, 1'b0);
    // DMA done flags: receive first, then transmit
    for (i = 0; i < 2; i++)
    begin
      wr(OFS_CTRL, i ? 32'h00040000 : 32'h00020000);
      {dtx, drx} <= i ? 2'h2 : 2'h1;
      @(posedge aclk);
      {dtx, drx} <= 2'h0;
      rd(OFS_STAT);
      chk_bit(rd_data[SB_RXDMA + i], 1'b1);
      chk_bit(irq, 1'b1);
      wr(OFS_CTRL, 32'h00000000);
      rd(OFS_STAT);
      chk_bit(irq, 1'b0);
      wr(OFS_STAT, 32'h00000000);
      rd(OFS_STAT);
      chk_bit(rd_data[SB_RXDMA + i], 1'b0);
    end
    // Loopback frames, second one overruns the unread first
    wr(OFS_DIV, 32'h00000003);
    wr(OFS_CTRL, 32'h00000A30);
    wr(OFS_DATA, 32'h000000A5);
    wr(OFS_EN, 32'h00000001);
    poll(SB_RXF);
    chk_bit(rxreq, 1'b1);
    chk_bit(txreq, 1'b1);
    chk_word(per, 32'h00000004);
    wr(OFS_DATA, 32'h0000003C);
    poll(SB_OVR);
    rdc(OFS_DATA, 32'h0000003C);
    rd(OFS_STAT);
    chk_bit(rd_data[SB_OVR], 1'b0);
    chk_bit(rd_data[SB_RXF], 1'b0);
    // All four clock modes, each width and both bit orders, against the peer
    // Slower clock leaves room for the pin output register and input synchroniser
    wr(OFS_DIV, 32'h0000000F);
    for (i = 0; i < 4; i++)
    begin
      wr(OFS_EN, 32'h00000000);
      nbits <= {i[1], ~i[1], 2'b00, i[0]};
      first_bit_order <= i[1] ^ i[0];
      clock_phase <= i[0];
      clock_idle_polarity <= i[1];
      wr(OFS_CTRL, {22'h0, 4'h8, 1'b1, i[1] ^ i[0], i[0], i[1], i[1:0]});
      wr(OFS_DATA, 32'h0001A5C3);
      wr(OFS_EN, 32'h00000001);
      poll(SB_RXF);
      mask = 17'h1FFFF >> (17 - nbits);
      rdc(OFS_DATA, {15'h0, 17'h0B4E9 & mask});
      chk_word({15'h0, prx}, {15'h0, 17'h1A5C3 & mask});
    end
    close_out();
  end
endmodule
